// [hw/pcs_top.sv]
`timescale 1ns/1ps
`include "pcs_cfg.svh"

// Notes on behaviour
// - Fifteen-bit PC; low byte readable and writable, upper bits come from latch.
// - Every reset clears the whole program counter.
// - Writing the PC low byte also loads PC bits 14..8 from latch.
// - Call loads PC 10..0 from operand, 14..11 from latch 6..3.
// - Computed call loads PC low from working register, high from latch.
// - Register branch: PC becomes PC plus one plus unsigned working register.
// - Immediate branch: PC becomes PC plus one plus signed operand bits 8..0.
// - Return stack holds sixteen fifteen-bit entries outside memory spaces.
// - Calls and vectoring push; the return command pops.
// - Pushes and pops leave the latch unchanged unless they cause an error reset, which clears it.
// - Without error reset the stack wraps and overwrites oldest entries.
// - Overflow and underflow flags set whether or not error reset is on.
// - Top-of-stack registers show the entry the pointer selects.
// - Stack pointer is five bits to detect overflow and underflow.
// - Push increments then writes; pop reads then decrements.
// - Empty stack pointer is 0x1F; first push gives 0x00.
// - With error reset on, overflow or underflow resets and sets flag.
// - Indirect access to an indirect register reads zero, drops writes.
// - Indirect pointer is sixteen bits from its high and low bytes.
// - Addresses 0x000 to 0xFFF map straight onto banked data memory.
// - 0x2000 to 0x29AF map onto general blocks; unimplemented reads zero.
// - Bit 15 set selects program memory; low byte read, no write.

module pcs_top (
    input  wire logic              clk,
    input  wire logic              ce,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire pcs_pkg::pcs_cmd_s cmd,
    output logic      [14:0]       pc_addr,
    output logic                   stack_reset_req,
    output pcs_pkg::pcs_map_s      ind_map0,
    output pcs_pkg::pcs_map_s      ind_map1
);

    // ****************************************************************
    // State.
    // ****************************************************************
    logic [14:0]       pc_ff;
    logic [6:0]        latch_ff;
    logic [4:0]        sp_ff;
    logic [15:0]       ptr_ff [2];
    pcs_pkg::pcs_map_s map_ff [2];
    logic              ovf_ff;
    logic              unf_ff;
    logic              ser_en_ff;
    logic              srst_ff;
    logic [31:0]       prdata_ff;
    logic              pready_ff;
    logic              pslverr_ff;

    logic [14:0]       nxt_pc;
    logic [4:0]        nxt_sp;
    logic [15:0]       nxt_ptr [2];
    logic              stk_we;
    logic [3:0]        stk_widx;
    logic [14:0]       stk_wdata;
    logic [14:0]       top_of_return;
    logic              do_push;
    logic [14:0]       push_val;
    logic              ovf_set;
    logic              unf_set;
    logic              stk_err;
    logic              commit;
    logic              wr;
    logic              flow_idle;
    logic [31:0]       rd_val;
    logic              rd_hit;

    // ****************************************************************
    // Address decoding helpers.
    // ****************************************************************
    function automatic logic [7:0] ptr_off(input int idx, input logic hi);
        ptr_off = 8'(`PCS_OFF_PTR_BASE + idx * `PCS_PTR_STRIDE
                     + (hi ? `PCS_PTR_HIGH_STEP : 8'h00));
    endfunction

    function automatic pcs_pkg::pcs_map_s decode_ptr(input logic [15:0] a);
        pcs_pkg::pcs_map_s m;
        logic [12:0]       off;
        logic [12:0]       bank;
        logic [12:0]       rem;
        m    = '0;
        off  = 13'(a - `PCS_LIN_BASE);
        bank = off / `PCS_LIN_BLOCK;
        rem  = off % `PCS_LIN_BLOCK;
        if (a[15])
        begin
            m.region      = pcs_pkg::PCS_REG_PROG;
            m.prog_addr   = a[14:0];
            m.no_write    = 1'b1;
            m.extra_cycle = 1'b1;
        end
        else if (a <= `PCS_TRAD_LAST)
        begin
            m.region    = pcs_pkg::PCS_REG_TRAD;
            m.data_addr = a[11:0];
            if (a[6:0] <= `PCS_IND_LAST)
            begin
                m.read_zero = 1'b1;
                m.no_write  = 1'b1;
            end
        end
        else if (a >= `PCS_LIN_BASE && a <= `PCS_LIN_LAST)
        begin
            m.region    = pcs_pkg::PCS_REG_LINEAR;
            m.data_addr = {bank[4:0], 7'h00} + `PCS_GPR_START
                          + {5'h00, rem[6:0]};
        end
        else
        begin
            // Holes in the map read as zero and swallow writes.
            m.region    = pcs_pkg::PCS_REG_NONE;
            m.read_zero = 1'b1;
            m.no_write  = 1'b1;
        end
        decode_ptr = m;
    endfunction

    // ****************************************************************
    // Bus slave.
    // ****************************************************************
    assign commit    = psel && penable && pready_ff;
    assign wr        = commit && pwrite;
    assign flow_idle = (cmd.op == pcs_pkg::PCS_OP_NONE);

    always_comb
    begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (paddr == `PCS_OFF_PC_LOW)
            rd_val = {24'h00_0000, pc_ff[7:0]};
        else if (paddr == `PCS_OFF_LATCH)
            rd_val = {25'h000_0000, latch_ff};
        else if (paddr == `PCS_OFF_SP)
            rd_val = {27'h000_0000, sp_ff};
        else if (paddr == `PCS_OFF_TOS_LOW)
            rd_val = {24'h00_0000, top_of_return[7:0]};
        else if (paddr == `PCS_OFF_TOS_HIGH)
            rd_val = {25'h000_0000, top_of_return[14:8]};
        else if (paddr == `PCS_OFF_STATUS)
            rd_val = {30'h0000_0000, unf_ff, ovf_ff};
        else if (paddr == `PCS_OFF_CTRL)
            rd_val = {31'h0000_0000, ser_en_ff};
        else
        begin
            rd_hit = 1'b0;
            for (int i = 0; i < 2; i++)
            begin
                if (paddr == ptr_off(i, 1'b0))
                begin
                    rd_val = {24'h00_0000, ptr_ff[i][7:0]};
                    rd_hit = 1'b1;
                end
                else if (paddr == ptr_off(i, 1'b1))
                begin
                    rd_val = {24'h00_0000, ptr_ff[i][15:8]};
                    rd_hit = 1'b1;
                end
            end
        end
    end

    // One wait state keeps read data and the answer both registered.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready_ff  <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !rd_hit;
            if (psel && penable && !pready_ff && !pwrite)
                prdata_ff <= rd_val;
        end
    end

    // ****************************************************************
    // Program counter and return stack control.
    // ****************************************************************
    always_comb
    begin
        nxt_pc    = pc_ff;
        nxt_sp    = sp_ff;
        stk_we    = 1'b0;
        stk_widx  = sp_ff[3:0];
        stk_wdata = top_of_return;
        do_push   = 1'b0;
        push_val  = 15'(pc_ff + 15'h0001);
        ovf_set   = 1'b0;
        unf_set   = 1'b0;
        case (cmd.op)
            pcs_pkg::PCS_OP_STEP:
                nxt_pc = 15'(pc_ff + 15'h0001);
            pcs_pkg::PCS_OP_CALL:
            begin
                do_push = 1'b1;
                nxt_pc  = {latch_ff[6:3], cmd.operand};
            end
            pcs_pkg::PCS_OP_COMPUTED_SUBROUTINE_JUMP:
            begin
                do_push = 1'b1;
                nxt_pc  = {latch_ff, cmd.wreg};
            end
            pcs_pkg::PCS_OP_VECTOR:
            begin
                do_push  = 1'b1;
                push_val = pc_ff;
                nxt_pc   = cmd.vector;
            end
            pcs_pkg::PCS_OP_RETURN:
            begin
                nxt_pc  = top_of_return;
                nxt_sp  = 5'(sp_ff - 5'h01);
                unf_set = (sp_ff == `PCS_SP_EMPTY);
            end
            pcs_pkg::PCS_OP_BRW:
                nxt_pc = 15'(pc_ff + 15'h0001 + {7'h00, cmd.wreg});
            pcs_pkg::PCS_OP_BRA:
                nxt_pc = 15'(pc_ff + 15'h0001
                             + {{6{cmd.operand[8]}}, cmd.operand[8:0]});
            default:
            begin
                if (wr && paddr == `PCS_OFF_PC_LOW)
                    nxt_pc = {latch_ff, pwdata[7:0]};
                if (wr && paddr == `PCS_OFF_SP)
                    nxt_sp = pwdata[4:0];
                if (wr && paddr == `PCS_OFF_TOS_LOW)
                begin
                    stk_we    = 1'b1;
                    stk_wdata = {top_of_return[14:8], pwdata[7:0]};
                end
                if (wr && paddr == `PCS_OFF_TOS_HIGH)
                begin
                    stk_we    = 1'b1;
                    stk_wdata = {pwdata[6:0], top_of_return[7:0]};
                end
            end
        endcase
        if (do_push)
        begin
            nxt_sp    = 5'(sp_ff + 5'h01);
            stk_we    = 1'b1;
            stk_widx  = nxt_sp[3:0];
            stk_wdata = push_val;
            ovf_set   = nxt_sp[4];
        end
        stk_err = ser_en_ff && (ovf_set || unf_set);
        if (stk_err)
        begin
            nxt_pc = `PCS_PC_RST;
            nxt_sp = `PCS_SP_EMPTY;
            stk_we = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pc_ff <= `PCS_PC_RST;
            sp_ff <= `PCS_SP_EMPTY;
        end
        else if (ce)
        begin
            pc_ff <= nxt_pc;
            sp_ff <= nxt_sp;
        end
    end

    // The latch is written by software and cleared by a stack error reset.
    always_ff @(posedge clk)
    begin
        if (reset)
            latch_ff <= `PCS_LATCH_RST;
        else if (ce && stk_err)
            latch_ff <= `PCS_LATCH_RST;
        else if (ce && wr && paddr == `PCS_OFF_LATCH)
            latch_ff <= pwdata[6:0];
    end

    // Flags survive the stack error reset so software can see its cause.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ovf_ff    <= 1'b0;
            unf_ff    <= 1'b0;
            ser_en_ff <= `PCS_CTRL_SER_RST;
            srst_ff   <= 1'b0;
        end
        else if (ce)
        begin
            srst_ff <= stk_err;
            if (ovf_set)
                ovf_ff <= 1'b1;
            else if (wr && paddr == `PCS_OFF_STATUS
                     && pwdata[`PCS_STAT_OVF_BIT])
                ovf_ff <= 1'b0;
            if (unf_set)
                unf_ff <= 1'b1;
            else if (wr && paddr == `PCS_OFF_STATUS
                     && pwdata[`PCS_STAT_UNF_BIT])
                unf_ff <= 1'b0;
            if (wr && paddr == `PCS_OFF_CTRL)
                ser_en_ff <= pwdata[`PCS_CTRL_SER_BIT];
        end
    end

    pcs_stack u_stack (
        .clk     (clk),
        .ce      (ce),
        .wr_en   (stk_we),
        .wr_idx  (stk_widx),
        .wr_data (stk_wdata),
        .rd_idx  (sp_ff[3:0]),
        .rd_data (top_of_return)
    );

    // ****************************************************************
    // Indirect pointers and their decoded map.
    // ****************************************************************
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            nxt_ptr[i] = ptr_ff[i];
            if (stk_err)
                nxt_ptr[i] = `PCS_PTR_RST;
            else if (wr && paddr == ptr_off(i, 1'b0))
                nxt_ptr[i][7:0] = pwdata[7:0];
            else if (wr && paddr == ptr_off(i, 1'b1))
                nxt_ptr[i][15:8] = pwdata[7:0];
        end
    end

    // Decoding the next value keeps the map in step with the pointer.
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (reset)
            begin
                ptr_ff[i] <= `PCS_PTR_RST;
                map_ff[i] <= decode_ptr(`PCS_PTR_RST);
            end
            else if (ce)
            begin
                ptr_ff[i] <= nxt_ptr[i];
                map_ff[i] <= decode_ptr(nxt_ptr[i]);
            end
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign pc_addr         = pc_ff;
    assign stack_reset_req = srst_ff;
    assign ind_map0        = map_ff[0];
    assign ind_map1        = map_ff[1];

    // ****************************************************************
    // Checks.
    // ****************************************************************
    a_pc_reset_clear: assert property (@(posedge clk)
        reset |=> pc_ff == `PCS_PC_RST)
        else $error("pc not cleared by reset");

    a_pc_low_load: assert property (@(posedge clk) disable iff (reset)
        ce && flow_idle && !stk_err && wr && paddr == `PCS_OFF_PC_LOW
        |=> pc_ff == {$past(latch_ff), $past(pwdata[7:0])})
        else $error("pc low write did not take latch");

    a_call_target: assert property (@(posedge clk) disable iff (reset)
        ce && cmd.op == pcs_pkg::PCS_OP_CALL && !stk_err
        |=> pc_ff == {$past(latch_ff[6:3]), $past(cmd.operand)})
        else $error("call target wrong");

    a_computed_subroutine_jump_target: assert property (@(posedge clk) disable iff (reset)
        ce && cmd.op == pcs_pkg::PCS_OP_COMPUTED_SUBROUTINE_JUMP && !stk_err
        |=> pc_ff == {$past(latch_ff), $past(cmd.wreg)})
        else $error("computed call target wrong");

    a_brw_target: assert property (@(posedge clk) disable iff (reset)
        ce && cmd.op == pcs_pkg::PCS_OP_BRW
        |=> pc_ff == 15'($past(pc_ff) + 15'h0001 + $past(cmd.wreg)))
        else $error("register branch target wrong");

    a_push_order: assert property (@(posedge clk) disable iff (reset)
        ce && cmd.op == pcs_pkg::PCS_OP_CALL && !stk_err
        |=> sp_ff == 5'($past(sp_ff) + 5'h01)
            && top_of_return == 15'($past(pc_ff) + 15'h0001))
        else $error("push did not store return address");

    a_empty_pop: assert property (@(posedge clk) disable iff (reset)
        ce && cmd.op == pcs_pkg::PCS_OP_RETURN && sp_ff == 5'h00
        |=> sp_ff == `PCS_SP_EMPTY)
        else $error("single pop did not restore empty code");

    a_ovf_flag: assert property (@(posedge clk) disable iff (reset)
        ce && do_push && sp_ff == 5'h0f |=> ovf_ff)
        else $error("overflow flag not set");

    a_err_reset: assert property (@(posedge clk) disable iff (reset)
        ce && ser_en_ff && unf_set
        |=> srst_ff && unf_ff && pc_ff == `PCS_PC_RST)
        else $error("stack error reset missing");

    a_prog_window: assert property (@(posedge clk) disable iff (reset)
        ptr_ff[0][15] |-> map_ff[0].region == pcs_pkg::PCS_REG_PROG
            && map_ff[0].no_write && map_ff[0].extra_cycle)
        else $error("program window not decoded");

    c_overflow: cover property (@(posedge clk) disable iff (reset)
        ce && ovf_set && !ser_en_ff);
    c_err_reset: cover property (@(posedge clk) disable iff (reset)
        srst_ff);
    c_linear: cover property (@(posedge clk) disable iff (reset)
        map_ff[1].region == pcs_pkg::PCS_REG_LINEAR);
    c_tos_write: cover property (@(posedge clk) disable iff (reset)
        ce && flow_idle && wr && paddr == `PCS_OFF_TOS_HIGH);

endmodule // pcs_top

// [hw/pcs_cfg.svh]
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ****************************************************************
// Register offsets on the bus.
// ****************************************************************
`define PCS_OFF_PC_LOW      8'h00
`define PCS_OFF_LATCH       8'h04
`define PCS_OFF_SP          8'h08
`define PCS_OFF_TOS_LOW     8'h0c
`define PCS_OFF_TOS_HIGH    8'h10
`define PCS_OFF_PTR_BASE    8'h14
`define PCS_PTR_STRIDE      8'h08
`define PCS_PTR_HIGH_STEP   8'h04
`define PCS_OFF_STATUS      8'h24
`define PCS_OFF_CTRL        8'h28

// ****************************************************************
// Field positions.
// ****************************************************************
`define PCS_STAT_OVF_BIT    0
`define PCS_STAT_UNF_BIT    1
`define PCS_CTRL_SER_BIT    0

// ****************************************************************
// Reset values and stack pointer codes.
// ****************************************************************
`define PCS_PC_RST          15'h0000
`define PCS_LATCH_RST       7'h00
`define PCS_PTR_RST         16'h0000
`define PCS_CTRL_SER_RST    1'b1
`define PCS_SP_EMPTY        5'h1f

// ****************************************************************
// Indirect address map.
// ****************************************************************
`define PCS_TRAD_LAST       16'h0fff
`define PCS_LIN_BASE        16'h2000
`define PCS_LIN_LAST        16'h29af
`define PCS_LIN_BLOCK       13'h0050
`define PCS_GPR_START       12'h020
`define PCS_IND_LAST        7'h01

`endif

// [hw/pcs_pkg.sv]
package pcs_pkg;

    // ****************************************************************
    // Flow commands from the instruction decoder.
    // ****************************************************************
    typedef enum logic [3:0] {
        PCS_OP_NONE,
        PCS_OP_STEP,
        PCS_OP_CALL,
        PCS_OP_COMPUTED_SUBROUTINE_JUMP,
        PCS_OP_VECTOR,
        PCS_OP_RETURN,
        PCS_OP_BRW,
        PCS_OP_BRA
    } pcs_op_e;

    typedef struct packed {
        pcs_op_e     op;
        logic [10:0] operand;
        logic [7:0]  wreg;
        logic [14:0] vector;
    } pcs_cmd_s;

    // ****************************************************************
    // Decoded indirect access.
    // ****************************************************************
    typedef enum logic [1:0] {
        PCS_REG_TRAD,
        PCS_REG_LINEAR,
        PCS_REG_PROG,
        PCS_REG_NONE
    } pcs_region_e;

    typedef struct packed {
        pcs_region_e region;
        logic [11:0] data_addr;
        logic [14:0] prog_addr;
        logic        read_zero;
        logic        no_write;
        logic        extra_cycle;
    } pcs_map_s;

endpackage

// [hw/pcs_stack.sv]
`timescale 1ns/1ps

module pcs_stack (
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_idx,
    input  wire logic [14:0] wr_data,
    input  wire logic [3:0]  rd_idx,
    output logic      [14:0] rd_data
);

    // ****************************************************************
    // Sixteen return entries, apart from program and data space.
    // ****************************************************************
    logic [14:0] entry_ff [16];

    always_ff @(posedge clk)
    begin
        if (ce && wr_en)
        begin
            entry_ff[wr_idx] <= wr_data;
        end
    end

    assign rd_data = entry_ff[rd_idx];

endmodule // pcs_stack

// [dv/pcs_decoder_model.sv]
`timescale 1ns/1ps

// ****************************************************************
// Decoder side: one flow command per core cycle.
// ****************************************************************
module pcs_decoder_model (
    input  wire pcs_pkg::pcs_op_e op,
    input  wire logic [10:0]      operand,
    input  wire logic [7:0]       wreg,
    input  wire logic [14:0]      vector,
    output pcs_pkg::pcs_cmd_s     cmd
);
    // The command is a level, so a held op repeats on every cycle.
    assign cmd = '{op: op, operand: operand, wreg: wreg, vector: vector};
endmodule // pcs_decoder_model

// [dv/pc_stack_indirect_addr_tb.sv]
`timescale 1ns/1ps
`include "pcs_cfg.svh"

module pc_stack_indirect_addr_tb;
    logic              clk = 1'b0;
    logic              ce = 1'b1;
    logic              reset = 1'b1;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [7:0]        paddr = 8'h00;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [14:0]       pc_addr;
    logic              stack_reset_req;
    pcs_pkg::pcs_op_e  op = pcs_pkg::PCS_OP_NONE;
    logic [10:0]       opnd = 11'h0;
    logic [7:0]        wreg = 8'h00;
    logic [14:0]       vec = 15'h0;
    pcs_pkg::pcs_cmd_s cmd;
    pcs_pkg::pcs_map_s m0;
    pcs_pkg::pcs_map_s m1;
    pcs_pkg::pcs_map_s m;
    logic [31:0]       rd;
    logic              er;
    int fails = 0, comparisons = 0, cyc = 0, seen = 0;
    int mpc = 0, msp = 31, mlat = 0, men = 1, movf = 0, munf = 0;
    int stk [16];
    int a, o, k;
    int tbl [6] = '{16'h0005, 16'h0081, 16'h2055, 16'h29af, 16'h8123, 16'h1000};

    pcs_decoder_model i_dec (.op(op), .operand(opnd), .wreg(wreg),
        .vector(vec), .cmd(cmd));
    pcs_top i_dut (.clk(clk), .ce(ce), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd),
        .pc_addr(pc_addr), .stack_reset_req(stack_reset_req),
        .ind_map0(m0), .ind_map1(m1));

    initial forever #2 clk = ~clk;

    // A hung handshake would otherwise stall the run for ever.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            final_report();
        end
    end

    always @(negedge clk) if (stack_reset_req === 1'b1) seen++;

    task final_report();
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input string n, input logic [7:0] ad, input int e);
        apb(1'b0, ad, 32'h0);
        chk(n, e, rd);
    endtask

    // ****************************************************************
    // Reference model of flow and stack.
    // ****************************************************************
    function void rstm();
        mpc = 0;
        msp = 31;
        mlat = 0;
    endfunction

    function bit push(input int v);
        msp = (msp + 1) & 31;
        if (msp > 15) movf = 1;
        if (msp > 15 && men)
        begin
            rstm();
            return 0;
        end
        stk[msp & 15] = v & 32767;
        return 1;
    endfunction

    function void pop();
        if (msp == 31) munf = 1;
        if (msp == 31 && men)
        begin
            rstm();
            return;
        end
        mpc = stk[msp & 15];
        msp = (msp - 1) & 31;
    endfunction

    task run(input pcs_pkg::pcs_op_e c, input logic [31:0] x);
        @(posedge clk);
        op <= c;
        opnd <= x[10:0];
        wreg <= x[18:11];
        vec <= x[14:0];
        @(negedge clk);
        chk("pc_addr", mpc, pc_addr);
        case (c)
            pcs_pkg::PCS_OP_STEP: mpc = (mpc + 1) & 32767;
            pcs_pkg::PCS_OP_CALL:
                if (push(mpc + 1)) mpc = (mlat >> 3) * 2048 + x[10:0];
            pcs_pkg::PCS_OP_COMPUTED_SUBROUTINE_JUMP:
                if (push(mpc + 1)) mpc = mlat * 256 + x[18:11];
            pcs_pkg::PCS_OP_VECTOR: if (push(mpc)) mpc = x[14:0];
            pcs_pkg::PCS_OP_RETURN: pop();
            pcs_pkg::PCS_OP_BRW: mpc = (mpc + 1 + x[18:11]) & 32767;
            pcs_pkg::PCS_OP_BRA:
                mpc = (mpc + 1 + x[8:0] - (x[8] ? 512 : 0)) & 32767;
            default: ;
        endcase
    endtask

    initial
    begin
        void'($urandom(19));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        run(pcs_pkg::PCS_OP_NONE, 0);
        // A low clock enable must hold the counter under a standing step.
        @(posedge clk);
        ce <= 1'b0;
        op <= pcs_pkg::PCS_OP_STEP;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        op <= pcs_pkg::PCS_OP_NONE;
        @(negedge clk);
        chk("pc_addr", mpc, pc_addr);
        rdchk("sp", `PCS_OFF_SP, 8'h1f);
        apb(1'b1, 8'hfc, 32'h0);
        chk("pslverr", 1, er);
        apb(1'b1, `PCS_OFF_LATCH, 32'h55);
        apb(1'b1, `PCS_OFF_PC_LOW, 32'ha3);
        mlat = 8'h55;
        mpc = 16'h55a3;
        rdchk("pc_low", `PCS_OFF_PC_LOW, 8'ha3);
        apb(1'b1, `PCS_OFF_CTRL, 32'h0);
        men = 0;
        repeat (17) run(pcs_pkg::PCS_OP_CALL, $urandom);
        run(pcs_pkg::PCS_OP_NONE, 0);
        rdchk("sp", `PCS_OFF_SP, msp);
        rdchk("latch", `PCS_OFF_LATCH, mlat);
        repeat (300)
        begin
            k = $urandom % 7 + 1;
            run(pcs_pkg::pcs_op_e'(k), $urandom);
        end
        run(pcs_pkg::PCS_OP_NONE, 0);
        rdchk("status", `PCS_OFF_STATUS, munf * 2 + movf);
        apb(1'b1, `PCS_OFF_STATUS, 32'h3);
        movf = 0;
        munf = 0;
        apb(1'b1, `PCS_OFF_SP, 32'h3);
        apb(1'b1, `PCS_OFF_TOS_LOW, 32'h5a);
        apb(1'b1, `PCS_OFF_TOS_HIGH, 32'h12);
        msp = 3;
        stk[3] = 16'h125a;
        rdchk("tos_high", `PCS_OFF_TOS_HIGH, 8'h12);
        run(pcs_pkg::PCS_OP_RETURN, 0);
        run(pcs_pkg::PCS_OP_NONE, 0);
        rdchk("sp", `PCS_OFF_SP, 8'h02);
        apb(1'b1, `PCS_OFF_SP, 32'h1f);
        msp = 31;
        run(pcs_pkg::PCS_OP_COMPUTED_SUBROUTINE_JUMP, $urandom);
        run(pcs_pkg::PCS_OP_RETURN, 0);
        run(pcs_pkg::PCS_OP_NONE, 0);
        rdchk("sp", `PCS_OFF_SP, 8'h1f);
        // Error reset on: an underflow and then an overflow.
        apb(1'b1, `PCS_OFF_CTRL, 32'h1);
        men = 1;
        run(pcs_pkg::PCS_OP_RETURN, 0);
        repeat (2) run(pcs_pkg::PCS_OP_NONE, 0);
        chk("stack_reset_req", 1, seen);
        rdchk("status", `PCS_OFF_STATUS, 8'h02);
        rdchk("latch", `PCS_OFF_LATCH, mlat);
        apb(1'b1, `PCS_OFF_SP, 32'h0f);
        msp = 15;
        run(pcs_pkg::PCS_OP_CALL, $urandom);
        repeat (2) run(pcs_pkg::PCS_OP_NONE, 0);
        chk("stack_reset_req", 2, seen);
        rdchk("sp", `PCS_OFF_SP, msp);
        for (k = 0; k < 6; k++)
        begin
            a = tbl[k];
            o = `PCS_OFF_PTR_BASE + (k % 2) * `PCS_PTR_STRIDE;
            apb(1'b1, 8'(o), a & 255);
            apb(1'b1, 8'(o + 4), a >> 8);
            run(pcs_pkg::PCS_OP_NONE, 0);
            m = (k % 2) ? m1 : m0;
            o = a - 8192;
            if (a[15])
            begin
                chk("region", pcs_pkg::PCS_REG_PROG, m.region);
                chk("prog_addr", a & 32767, m.prog_addr);
                chk("extra", 1, m.extra_cycle);
                chk("no_write", 1, m.no_write);
            end
            else if (a < 4096)
            begin
                chk("data_addr", a, m.data_addr);
                chk("read_zero", a % 128 < 2, m.read_zero);
                chk("no_write", a % 128 < 2, m.no_write);
            end
            else if (a >= 16'h2000 && a <= 16'h29af)
            begin
                chk("region", pcs_pkg::PCS_REG_LINEAR, m.region);
                chk("data", o / 80 * 128 + 32 + o % 80, m.data_addr);
            end
            else chk("read_zero", 1, m.read_zero);
        end
        rdchk("ptr_high", `PCS_OFF_PTR_BASE + `PCS_PTR_STRIDE
              + `PCS_PTR_HIGH_STEP, 8'h10);
        final_report();
    end
endmodule // pc_stack_indirect_addr_tb
